/* File: tb/tb.sv */
// Testbench top for vap_formatter with receiver model and checker.
// Assumes inputs change at the falling edge of clk_in.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import vap_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic std_ntsc_in = 1'b1, slice_valid_in = 1'b0, slice_caption_in = 1'b0, slice_double_in = 1'b0;
  logic slice_even_in = 1'b0, hblank_start_in = 1'b0, anc_active_out;
  logic [3:0] slice_line_in = 4'h0;
  logic [31:0] slice_bytes_in = 32'h0;
  logic [9:0] vid_data_in = 10'h040, vid_data_out, rx_words [16];
  int rx_len, rx_pkts, n_errors, samples_checked, cyc;
  vap_formatter DUT (.clk_in, .resetn_in, .ce_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .std_ntsc_in, .slice_valid_in, .slice_caption_in, .slice_double_in, .slice_even_in,
    .slice_line_in, .slice_bytes_in, .hblank_start_in, .vid_data_in, .vid_data_out, .anc_active_out);
  vap_rx_model u_rx (.clk_in, .vid_in(vid_data_out), .active_in(anc_active_out), .words_out(rx_words),
    .len_out(rx_len), .pkts_out(rx_pkts));
  always #4 clk_in = ~clk_in;
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      finish_test;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [9:0] par(input logic [7:0] d);
    return {~^d, ^d, d};
  endfunction
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    chk("register", reg_rdata_out, e);
  endtask
  task automatic run_pkt(input logic cap, dbl, ev, pk, ntsc, input logic [3:0] ln, input logic [31:0] b,
                         input int want);
    logic [9:0] w [16];
    logic [6:0] s;
    int n, nb, p0;
    wr(ADDR_PACKING, {7'h00, pk});
    std_ntsc_in = ntsc;
    p0 = rx_pkts;
    @(negedge clk_in);
    slice_valid_in = 1'b1;
    slice_caption_in = cap;
    slice_double_in = dbl;
    slice_even_in = ev;
    slice_line_in = ln;
    slice_bytes_in = b;
    @(negedge clk_in);
    slice_valid_in = 1'b0;
    hblank_start_in = 1'b1;
    @(negedge clk_in);
    hblank_start_in = 1'b0;
    repeat (18) @(negedge clk_in);
    chk("packets", rx_pkts - p0, want);
    if (want == 0) return;
    nb = (dbl && !cap) ? 4 : 2;
    w[0] = 10'h000;
    w[1] = 10'h3ff;
    w[2] = 10'h3ff;
    w[3] = 10'h140;
    w[4] = par({ev, dbl & ~cap, ln, 2'b00});
    n = 6;
    for (int i = 0; i < nb; i++) begin
      if (pk) begin
        w[n] = {b[8*i +: 8], 2'b00};
        n++;
      end else begin
        w[n] = par({2'b00, b[8*i+4 +: 4], 2'b00});
        w[n+1] = par({2'b00, b[8*i +: 4], 2'b00});
        n += 2;
      end
    end
    while (n % 4 != 2) begin
      w[n] = 10'h200;
      n++;
    end
    w[5] = par({4'h0, 2'((n - 6) / 4), 2'b00});
    s = 7'h00;
    for (int i = 3; i < n; i++) s += w[i][8:2];
    w[n] = {~s[6], s, 2'b00};
    n++;
    chk("length", rx_len, n);
    for (int i = 0; i < n; i++) chk("word", rx_words[i], w[i]);
  endtask
  task automatic t_regs;
    rd(ADDR_EVEN_EN_LO, 8'h00);
    rd(ADDR_PACKING, 8'h00);
    wr(ADDR_EVEN_EN_LO, 8'h20);
    wr(ADDR_ODD_EN_HI, 8'h10);
    rd(ADDR_EVEN_EN_LO, 8'h20);
    rd(ADDR_ODD_EN_HI, 8'h10);
    ce_in = 1'b0;
    wr(ADDR_PACKING, 8'h01);
    ce_in = 1'b1;
    rd(ADDR_PACKING, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_modes;
    run_pkt(0, 1, 1, 0, 1, 4'h5, 32'ha53c817e, 1);
    run_pkt(0, 1, 1, 1, 1, 4'h5, 32'hff00c3e1, 1);
    run_pkt(0, 0, 1, 0, 1, 4'h5, 32'h00007f80, 1);
    run_pkt(0, 0, 1, 1, 1, 4'h5, 32'h0000fe01, 1);
    run_pkt(1, 1, 0, 0, 0, 4'hc, 32'h12349d62, 1);
    $display("test modes done");
  endtask
  task automatic t_drop;
    run_pkt(0, 0, 1, 0, 0, 4'h5, 32'h00001111, 0);
    run_pkt(0, 0, 0, 0, 1, 4'h5, 32'h00002222, 0);
    run_pkt(0, 1, 1, 1, 1, 4'hc, 32'h33334444, 0);
    chk("passthrough", vid_data_out, 10'h040);
    $display("test drop done");
  endtask
  task automatic t_pend;
    int p0;
    p0 = rx_pkts;
    @(negedge clk_in);
    slice_valid_in = 1'b1;
    slice_caption_in = 1'b1;
    slice_even_in = 1'b1;
    slice_line_in = 4'h5;
    @(negedge clk_in);
    slice_valid_in = 1'b0;
    rd(ADDR_STATUS, 8'h01);
    hblank_start_in = 1'b1;
    @(negedge clk_in);
    hblank_start_in = 1'b0;
    slice_valid_in = 1'b1;
    @(negedge clk_in);
    slice_valid_in = 1'b0;
    rd(ADDR_STATUS, 8'h02);
    repeat (16) @(negedge clk_in);
    chk("pend packets", rx_pkts - p0, 1);
    rd(ADDR_STATUS, 8'h00);
    resetn_in = 1'b0;
    @(negedge clk_in);
    resetn_in = 1'b1;
    rd(ADDR_EVEN_EN_LO, 8'h00);
    rd(ADDR_PACKING, 8'h00);
    $display("test pend done");
  endtask
  initial begin
    repeat (3) @(negedge clk_in);
    resetn_in = 1'b1;
    t_regs;
    t_modes;
    t_drop;
    t_pend;
    finish_test;
  end
endmodule
bind vap_formatter vap_checker u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
  .hblank_start_in(hblank_start_in), .vid_data_out(vid_data_out), .anc_active_out(anc_active_out));
`default_nettype wire

/* File: tb/vap_checker.sv */
// Assertions on the packet output of vap_formatter.
// Assumes a bind onto vap_formatter; clk_in is the only clock.
`timescale 1ns/10ps
`default_nettype none
module vap_checker (
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       ce_in,
  input wire logic       hblank_start_in,
  input wire logic [9:0] vid_data_out,
  input wire logic       anc_active_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in || !ce_in);
  a_pre_zero: assert property ($rose(anc_active_out) |-> vid_data_out == 10'h000)
    else $error("first word not zero");
  a_pre_ones: assert property ($rose(anc_active_out) |=> vid_data_out == 10'h3ff ##1 vid_data_out == 10'h3ff)
    else $error("preamble ones missing");
  a_did_word: assert property ($rose(anc_active_out) |-> ##3 vid_data_out == 10'h140)
    else $error("id word wrong");
  a_sdid_low: assert property ($rose(anc_active_out) |-> ##4 vid_data_out[1:0] == 2'b00)
    else $error("secondary id low bits set");
  a_hdr_parity: assert property ($rose(anc_active_out) |-> ##4 (^vid_data_out[8:0] == 1'b0 &&
    vid_data_out[9] != vid_data_out[8]) [*2]) else $error("header parity wrong");
  a_pkt_len: assert property ($rose(anc_active_out) |-> anc_active_out [*8] ##1 anc_active_out [*3] ##1
    ((!anc_active_out) or (anc_active_out [*4] ##1 !anc_active_out))) else $error("packet length wrong");
  a_dc_long: assert property ($rose(anc_active_out) ##5 vid_data_out[3:2] == 2'b10 |->
    ##9 anc_active_out ##1 !anc_active_out) else $error("long count mismatch");
  a_dc_short: assert property ($rose(anc_active_out) ##5 vid_data_out[3:2] == 2'b01 |->
    ##5 anc_active_out ##1 !anc_active_out) else $error("short count mismatch");
  a_cs_inv: assert property ($fell(anc_active_out) |-> $past(vid_data_out[9]) != $past(vid_data_out[8]))
    else $error("checksum bit 9 wrong");
  a_cs_low: assert property ($fell(anc_active_out) |-> $past(vid_data_out[1:0]) == 2'b00)
    else $error("checksum low bits set");
  a_after_eav: assert property ($rose(anc_active_out) |-> $past(hblank_start_in))
    else $error("packet not after blanking start");
endmodule
`default_nettype wire

/* File: tb/vap_rx_model.sv */
// Downstream video receiver model: gathers each packet word by word.
// Assumes packet words are flagged by anc_active_out, one per clk_in.
`timescale 1ns/10ps
`default_nettype none
module vap_rx_model (
  input  wire logic       clk_in,
  input  wire logic [9:0] vid_in,
  input  wire logic       active_in,
  output logic      [9:0] words_out [16],
  output int              len_out,
  output int              pkts_out
);
  bit prev_q;
  // Whole words kept; an 8-bit reader would drop bits 1:0
  always @(posedge clk_in) begin
    if (active_in && !prev_q) begin
      pkts_out <= pkts_out + 1;
      len_out <= 1;
      words_out[0] <= vid_in;
    end else if (active_in && len_out < 16) begin
      words_out[len_out] <= vid_in;
      len_out <= len_out + 1;
    end
    prev_q <= active_in;
  end
endmodule
`default_nettype wire

/* File: verilog/vap_formatter.sv */
// Ancillary packet formatter: captures sliced line data, inserts packets after EAV.
// Assumes hblank_start_in pulses on the first word after EAV and slicer inputs are clk_in synchronous.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Two 16-bit line enable masks, even and odd field, gate capture per line.
// - Packet only when line enabled and slicer reported data for that line.
// - Packet starts right after EAV; payload never readable on register port.
// - Packet opens with preamble words 000, 3ff, 3ff.
// - Data identification word is 140 for guide data and caption alike.
// - Secondary id: bit 7 even field flag, bit 6 double rate flag.
// - Secondary id bits 5:2 hold the line code, bits 1:0 zero.
// - Id, count and nibble words: bit 8 even parity, bit 9 its inverse.
// - Count word bits 3:2 hold number of user words divided by four.
// - Sizes: 2x nibble 8/10, else 4/01; 1x byte has two pads.
// - Byte packing sends byte per word; nibble sends high then low nibble.
// - Pad words fill user section to a multiple of four words.
// - Checksum sums bits 8:2 of id, count and user words, low bits zero.
// - Checksum bit 9 is inverse of checksum bit 8.
// - Guide data only from NTSC; caption data from PAL and NTSC.
// - Packing bit 0 selects nibble packing, 1 selects byte packing.
module vap_formatter
  import vap_pkg::*;
#(
  parameter int LINES = 16
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        std_ntsc_in,
  input  wire logic        slice_valid_in,
  input  wire logic        slice_caption_in,
  input  wire logic        slice_double_in,
  input  wire logic        slice_even_in,
  input  wire logic [3:0]  slice_line_in,
  input  wire logic [31:0] slice_bytes_in,
  input  wire logic        hblank_start_in,
  input  wire logic [9:0]  vid_data_in,
  output logic      [9:0]  vid_data_out,
  output logic             anc_active_out
);
  import vap_pkg::*;

  // Configuration registers
  logic [LINES-1:0] even_field_line_enable_q;
  logic [LINES-1:0] odd_field_line_enable_q;
  logic             payload_packing_select_q;
  logic [7:0]       reg_rdata_q;

  // Sequencer state, captured line data, word index, checksum and output registers
  vap_state_e  state_q;
  vap_state_e  state_d;
  logic        even_field_flag_q;
  logic        double_rate_flag_q;
  logic        pack_byte_q;
  logic [3:0]  line_q;
  logic [31:0] bytes_q;
  logic [3:0]  idx_q;
  logic [6:0]  csum_q;
  logic [9:0]  vid_q;
  logic        active_q;

  // Register decode
  wire wr_even_lo;
  wire wr_even_hi;
  wire wr_odd_lo;
  wire wr_odd_hi;
  wire wr_pack;
  assign wr_even_lo = ce_in && reg_wr_in && (reg_addr_in == ADDR_EVEN_EN_LO);
  assign wr_even_hi = ce_in && reg_wr_in && (reg_addr_in == ADDR_EVEN_EN_HI);
  assign wr_odd_lo  = ce_in && reg_wr_in && (reg_addr_in == ADDR_ODD_EN_LO);
  assign wr_odd_hi  = ce_in && reg_wr_in && (reg_addr_in == ADDR_ODD_EN_HI);
  assign wr_pack    = ce_in && reg_wr_in && (reg_addr_in == ADDR_PACKING);

  wire [7:0] status_byte;
  assign status_byte = {6'h00, (state_q == ST_SEND), (state_q == ST_PEND)};

  // Payload is absent from the read mux on purpose
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr_in)
      ADDR_EVEN_EN_LO: rd_mux = even_field_line_enable_q[7:0];
      ADDR_EVEN_EN_HI: rd_mux = even_field_line_enable_q[15:8];
      ADDR_ODD_EN_LO:  rd_mux = odd_field_line_enable_q[7:0];
      ADDR_ODD_EN_HI:  rd_mux = odd_field_line_enable_q[15:8];
      ADDR_PACKING:    rd_mux = {7'h00, payload_packing_select_q};
      ADDR_STATUS:     rd_mux = status_byte;
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      even_field_line_enable_q <= LINE_EN_RESET;
      odd_field_line_enable_q  <= LINE_EN_RESET;
    end else begin
      if (wr_even_lo) even_field_line_enable_q[7:0]  <= reg_wdata_in;
      if (wr_even_hi) even_field_line_enable_q[15:8] <= reg_wdata_in;
      if (wr_odd_lo)  odd_field_line_enable_q[7:0]   <= reg_wdata_in;
      if (wr_odd_hi)  odd_field_line_enable_q[15:8]  <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      payload_packing_select_q <= PACKING_RESET;
    end else if (wr_pack) begin
      payload_packing_select_q <= reg_wdata_in[PACKING_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_q <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      reg_rdata_q <= rd_mux;
    end
  end
  assign reg_rdata_out = reg_rdata_q;

  // Capture qualification
  wire line_enabled;
  wire std_ok;
  wire capture;
  assign line_enabled = slice_even_in ? even_field_line_enable_q[slice_line_in]
                                      : odd_field_line_enable_q[slice_line_in];
  assign std_ok  = slice_caption_in || std_ntsc_in;
  assign capture = slice_valid_in && line_enabled && std_ok && (state_q != ST_SEND);

  // Packet geometry
  wire       nibble_mode;
  wire [3:0] udw_count;
  wire [3:0] idx_cs;
  wire [1:0] dc_code;
  wire       in_udw;
  wire [3:0] udw_idx;
  assign nibble_mode = (pack_byte_q == PACK_NIBBLE);
  assign udw_count   = (double_rate_flag_q && nibble_mode) ? UDW_LONG : UDW_SHORT;
  assign dc_code     = (double_rate_flag_q && nibble_mode) ? DC_EIGHT : DC_FOUR;
  assign idx_cs      = IDX_UDW0 + udw_count;
  assign in_udw      = (idx_q >= IDX_UDW0) && (idx_q < idx_cs);
  assign udw_idx     = idx_q - IDX_UDW0;

  // Raw byte and nibble selection
  wire [1:0] byte_sel;
  wire [7:0] raw_byte;
  wire [3:0] raw_nib;
  wire [3:0] raw_bytes_n;
  wire       is_pad;
  assign byte_sel    = nibble_mode ? udw_idx[2:1] : udw_idx[1:0];
  assign raw_byte    = bytes_q[{byte_sel, 3'b000} +: 8];
  assign raw_nib     = udw_idx[0] ? raw_byte[3:0] : raw_byte[7:4];
  assign raw_bytes_n = double_rate_flag_q ? UDW_SHORT : CC_BYTES;
  assign is_pad      = !nibble_mode && (udw_idx >= raw_bytes_n);

  // Bodies that receive parity
  wire [7:0] sdid_body;
  wire [7:0] dc_body;
  wire [7:0] nib_body;
  assign sdid_body = {even_field_flag_q, double_rate_flag_q, line_q, 2'b00};
  assign dc_body   = {4'h0, dc_code, 2'b00};
  assign nib_body  = {2'b00, raw_nib, 2'b00};

  logic [7:0] par_body;
  always_comb begin
    if (idx_q == IDX_SDID) begin
      par_body = sdid_body;
    end else if (idx_q == IDX_DC) begin
      par_body = dc_body;
    end else begin
      par_body = nib_body;
    end
  end

  wire [9:0] par_word;
  vap_parity_word #(
    .W (8)
  ) u_parity (
    .body_in  (par_body),
    .word_out (par_word)
  );

  // Checksum word, bits 1:0 always zero
  wire [9:0] cs_word;
  assign cs_word = {~csum_q[6], csum_q, 2'b00};

  logic [9:0] pkt_word;
  always_comb begin
    if (idx_q == IDX_PRE0) begin
      pkt_word = WORD_PRE_ZERO;
    end else if (idx_q == IDX_PRE1 || idx_q == IDX_PRE2) begin
      pkt_word = WORD_PRE_ONES;
    end else if (idx_q == IDX_DID) begin
      pkt_word = WORD_DID;
    end else if (idx_q == IDX_SDID || idx_q == IDX_DC) begin
      pkt_word = par_word;
    end else if (in_udw && nibble_mode) begin
      pkt_word = par_word;
    end else if (in_udw && is_pad) begin
      pkt_word = WORD_PAD;
    end else if (in_udw) begin
      pkt_word = {raw_byte, 2'b00};
    end else begin
      pkt_word = cs_word;
    end
  end

  wire last_word;
  wire start_pkt;
  assign last_word = (state_q == ST_SEND) && (idx_q == idx_cs);
  assign start_pkt = (state_q == ST_PEND) && hblank_start_in;

  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (capture) state_d = ST_PEND;
      ST_PEND: if (start_pkt) state_d = ST_SEND;
      ST_SEND: if (last_word) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
    end else if (ce_in) begin
      state_q <= state_d;
    end
  end

  // Captured line data; a newer slice replaces a pending one
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      even_field_flag_q  <= 1'b0;
      double_rate_flag_q <= 1'b0;
      pack_byte_q        <= PACKING_RESET;
      line_q             <= 4'h0;
      bytes_q            <= 32'h0000_0000;
    end else if (ce_in && capture) begin
      even_field_flag_q  <= slice_even_in;
      double_rate_flag_q <= slice_double_in && !slice_caption_in;
      pack_byte_q        <= payload_packing_select_q;
      line_q             <= slice_line_in;
      bytes_q            <= slice_bytes_in;
    end
  end

  // Word index and running checksum
  wire word_step;
  assign word_step = (state_q == ST_SEND) && !last_word;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx_q <= IDX_PRE0;
    end else if (ce_in) begin
      if (start_pkt) begin
        idx_q <= IDX_PRE1;
      end else if (word_step) begin
        idx_q <= idx_q + 4'h1;
      end else if (last_word) begin
        idx_q <= IDX_PRE0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      csum_q <= 7'h00;
    end else if (ce_in) begin
      if (start_pkt) begin
        csum_q <= 7'h00;
      end else if (word_step && (idx_q == IDX_DID)) begin
        csum_q <= pkt_word[8:2];
      end else if (word_step && (idx_q > IDX_DID)) begin
        csum_q <= csum_q + pkt_word[8:2];
      end
    end
  end

  // Output word: packet replaces blanking words, else stream passes through
  wire       sending;
  wire [9:0] out_d;
  assign sending = start_pkt || (state_q == ST_SEND);
  assign out_d   = start_pkt ? WORD_PRE_ZERO : ((state_q == ST_SEND) ? pkt_word : vid_data_in);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vid_q    <= 10'h000;
      active_q <= 1'b0;
    end else if (ce_in) begin
      vid_q    <= out_d;
      active_q <= sending;
    end
  end
  assign vid_data_out   = vid_q;
  assign anc_active_out = active_q;
endmodule
`default_nettype wire

/* File: verilog/vap_parity_word.sv */
// Adds even parity over bits 8:0 and its inverse in bit 9 to an 8-bit body.
// Assumes the body already carries zeros in its two low bits where needed.
`timescale 1ns/10ps
`default_nettype none
module vap_parity_word #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] body_in,
  output logic      [W+1:0] word_out
);
  wire parity_bit;
  assign parity_bit = ^body_in;
  assign word_out   = {~parity_bit, parity_bit, body_in};
endmodule
`default_nettype wire

/* File: verilog/vap_pkg.sv */
// Constants for the ancillary packet formatter: register map, packet words, layout.
// Assumes a 10-bit BT.656 word path and an 8-bit sub-address register port.
`default_nettype none
package vap_pkg;
  // Register sub-addresses
  localparam logic [7:0] ADDR_EVEN_EN_LO    = 8'h48;
  localparam logic [7:0] ADDR_EVEN_EN_HI    = 8'h49;
  localparam logic [7:0] ADDR_ODD_EN_LO     = 8'h4a;
  localparam logic [7:0] ADDR_ODD_EN_HI     = 8'h4b;
  localparam logic [7:0] ADDR_PACKING       = 8'h4c;
  localparam logic [7:0] ADDR_STATUS        = 8'h4d;
  // Reset values
  localparam logic [15:0] LINE_EN_RESET     = 16'h0000;
  localparam logic        PACKING_RESET     = 1'b0;
  localparam int          PACKING_BIT       = 0;
  localparam logic        PACK_NIBBLE       = 1'b0;
  // Fixed packet words
  localparam logic [9:0] WORD_PRE_ZERO      = 10'h000;
  localparam logic [9:0] WORD_PRE_ONES      = 10'h3ff;
  localparam logic [9:0] WORD_DID           = 10'h140;
  localparam logic [9:0] WORD_PAD           = 10'h200;
  // Data count codes
  localparam logic [1:0] DC_FOUR            = 2'b01;
  localparam logic [1:0] DC_EIGHT           = 2'b10;
  // Word positions inside a packet
  localparam logic [3:0] IDX_PRE0           = 4'h0;
  localparam logic [3:0] IDX_PRE1           = 4'h1;
  localparam logic [3:0] IDX_PRE2           = 4'h2;
  localparam logic [3:0] IDX_DID            = 4'h3;
  localparam logic [3:0] IDX_SDID           = 4'h4;
  localparam logic [3:0] IDX_DC             = 4'h5;
  localparam logic [3:0] IDX_UDW0           = 4'h6;
  localparam logic [3:0] UDW_SHORT          = 4'h4;
  localparam logic [3:0] UDW_LONG           = 4'h8;
  localparam logic [3:0] CC_BYTES           = 4'h2;
  // Sequencer states, Gray along idle -> pending -> sending
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PEND = 2'b01,
    ST_SEND = 2'b11
  } vap_state_e;
endpackage
`default_nettype wire
